//--- sfm_pkg.sv
// Constants, register map and fault code table of the servo fault monitor
package sfm_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_MHZ = 50;
  localparam int DISC_TIME_US = 1000;
  localparam int DISC_TIME_CYC = DISC_TIME_US * CLK_MHZ;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_CODE = 8'h0c;
  localparam logic [7:0] OFS_POS_LIM = 8'h10;
  localparam logic [7:0] OFS_SPD_LIM = 8'h14;
  localparam logic [7:0] OFS_HYB_LIM = 8'h18;
  localparam logic [7:0] OFS_OVS1 = 8'h1c;
  localparam logic [7:0] OFS_OVS2 = 8'h20;
  localparam logic [7:0] OFS_RATIO_NUM = 8'h24;
  localparam logic [7:0] OFS_RATIO_DEN = 8'h28;
  localparam logic [7:0] OFS_DISC_TMO = 8'h2c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_FULL_CLOSED = 0;
  localparam int CTRL_DIR_REV = 1;
  localparam int CTRL_CODE_CLEAR = 2;
  localparam int CODE_SUB_LSB = 8;
  localparam int CODE_VALID_BIT = 16;

  // Fault bit index in status and mask
  localparam int F_DISC = 0;
  localparam int F_COMM = 1;
  localparam int F_DATA = 2;
  localparam int F_POS = 3;
  localparam int F_SPD = 4;
  localparam int F_HYB = 5;
  localparam int F_OVS1 = 6;
  localparam int F_OVS2 = 7;
  localparam int NFAULT = 8;

  // Main and sub code of each fault bit
  localparam logic [7:0] FAULT_MAIN [NFAULT] = '{8'h15, 8'h15, 8'h17, 8'h18, 8'h18, 8'h19, 8'h1a, 8'h1a};
  localparam logic [7:0] FAULT_SUB [NFAULT] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01};

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] RST_POS_LIM = 32'h0000_4e20;
  localparam logic [31:0] RST_SPD_LIM = 32'h0000_0000;
  localparam logic [31:0] RST_HYB_LIM = 32'h0000_4e20;
  localparam logic [31:0] RST_OVS1 = 32'h0000_1770;
  localparam logic [31:0] RST_OVS2 = 32'h0000_1b58;
  localparam logic [15:0] RST_RATIO = 16'h0001;
  localparam logic [7:0] RST_MASK = 8'hff;

endpackage

//--- sfm_top.sv
// Servo fault monitor: encoder link, deviation and over-speed checks with AHB-Lite registers
//
// Operation
// [R1] Raise encoder disconnection fault when no valid frame arrives within the timeout.
// [R2] Raise 21.1 when a frame shows a transport error while link connected.
// [R3] Raise 23.0 when an error-free frame carries data failing validity check.
// [R4] Raise 24.0 when position deviation magnitude exceeds position deviation limit.
// [R5] Raise 24.1 when command speed minus actual speed magnitude exceeds limit.
// [R6] A speed deviation limit of zero disables the speed deviation check.
// [R7] Over-travel stop forces command speed to zero; deviation check keeps running.
// [R8] In full-closed mode raise 25.0 when load and motor positions differ too much.
// [R9] Raise 26.0 when motor speed magnitude exceeds the first over-speed level.
// [R10] Raise 26.1 when motor speed magnitude exceeds the second over-speed level.
// [R11] Scale external position by numerator/denominator and direction before hybrid compare.
// [R12] Latch each fault, and the main/sub code of the first one, until explicitly cleared.
`timescale 1ns/10ps

module sfm_top
  import sfm_pkg::*;
#(
  parameter logic [31:0] DISC_TIMEOUT_CYC = 32'(DISC_TIME_CYC)
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Encoder frame decoder
  input wire logic enc_frame_stb,
  input wire logic enc_frame_err,
  input wire logic enc_data_bad,
  // Control loop feedback
  input wire logic signed [31:0] position_deviation,
  input wire logic signed [31:0] cmd_speed,
  input wire logic signed [31:0] actual_speed,
  input wire logic signed [31:0] motor_position,
  input wire logic signed [31:0] scale_position,
  // Over-travel inhibit pin
  input wire logic overtravel_stop,
  // Effective command speed and fault outputs
  output logic signed [31:0] cmd_speed_eff,
  output logic fault_valid,
  output logic [7:0] fault_main,
  output logic [7:0] fault_sub,
  output logic irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic full_closed;
    logic scale_direction_reverse;
    logic [NFAULT-1:0] status;
    logic [NFAULT-1:0] mask;
    logic [31:0] position_deviation_limit;
    logic [31:0] speed_deviation_limit;
    logic [31:0] hybrid_deviation_limit;
    logic [31:0] overspeed_level;
    logic [31:0] second_overspeed_level;
    logic [15:0] scale_ratio_numerator;
    logic [15:0] scale_ratio_denominator;
    logic [31:0] disc_timeout;
    logic [31:0] disc_cnt;
    logic disc_flag;
    logic code_valid;
    logic [7:0] code_main;
    logic [7:0] code_sub;
    logic ot_meta;
    logic ot_sync;
    logic signed [31:0] cmd_eff;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
  } sfm_state_s;

  sfm_state_s st;
  sfm_state_s next_st;

  // ****************************************
  // Checks
  // ****************************************
  logic frame_ok;
  logic [31:0] next_disc_cnt;
  logic next_disc;
  logic signed [31:0] eff_cmd;
  logic signed [32:0] spd_diff;
  logic [32:0] spd_diff_abs;
  logic [31:0] pos_dev_abs;
  logic [31:0] speed_abs;
  logic signed [49:0] mot_scaled;
  logic signed [49:0] scl_scaled;
  logic signed [49:0] hyb_diff;
  logic [49:0] hyb_diff_abs;
  logic [49:0] hyb_lim_scaled;
  logic [NFAULT-1:0] detect;

  assign frame_ok = enc_frame_stb & ~enc_frame_err;

  always_comb
  begin
    if (frame_ok)
    begin
      next_disc_cnt = 32'h0000_0000;
    end
    else if (st.disc_cnt != st.disc_timeout)
    begin
      next_disc_cnt = st.disc_cnt + 32'h0000_0001;
    end
    else
    begin
      next_disc_cnt = st.disc_cnt;
    end
  end

  assign next_disc = (st.disc_timeout != 32'h0000_0000) && (next_disc_cnt == st.disc_timeout); // R1

  // Command speed seen by the loop and by the deviation check
  assign eff_cmd = st.ot_sync ? 32'sh0000_0000 : cmd_speed; // R7
  assign spd_diff = 33'(eff_cmd) - 33'(actual_speed); // R7
  assign spd_diff_abs = spd_diff[32] ? 33'(-spd_diff) : 33'(spd_diff);
  assign pos_dev_abs = position_deviation[31] ? 32'(-position_deviation) : 32'(position_deviation);
  assign speed_abs = actual_speed[31] ? 32'(-actual_speed) : 32'(actual_speed);

  // Cross-multiplied ratio avoids a divider: motor*den versus scale*num
  assign mot_scaled = 50'(motor_position) * $signed({34'h0, st.scale_ratio_denominator}); // R11
  assign scl_scaled = st.scale_direction_reverse
    ? 50'(-(50'(scale_position) * $signed({34'h0, st.scale_ratio_numerator})))
    : 50'(scale_position) * $signed({34'h0, st.scale_ratio_numerator}); // R11
  assign hyb_diff = mot_scaled - scl_scaled;
  assign hyb_diff_abs = hyb_diff[49] ? 50'(-hyb_diff) : 50'(hyb_diff);
  assign hyb_lim_scaled = {18'h0, st.hybrid_deviation_limit} * {34'h0, st.scale_ratio_denominator}; // R11

  always_comb
  begin
    detect = '0;
    detect[F_DISC] = next_disc & ~st.disc_flag; // R1
    detect[F_COMM] = enc_frame_stb & enc_frame_err & ~st.disc_flag; // R2
    detect[F_DATA] = frame_ok & enc_data_bad; // R3
    detect[F_POS] = pos_dev_abs > st.position_deviation_limit; // R4
    detect[F_SPD] = (st.speed_deviation_limit != 32'h0000_0000)
      && (spd_diff_abs > {1'b0, st.speed_deviation_limit}); // R5 R6
    detect[F_HYB] = st.full_closed && (hyb_diff_abs > hyb_lim_scaled); // R8
    detect[F_OVS1] = speed_abs > st.overspeed_level; // R9
    detect[F_OVS2] = speed_abs > st.second_overspeed_level; // R10
  end

  // ****************************************
  // Bus decode
  // ****************************************
  logic wr_en;
  logic ap_take;

  assign wr_en = st.ap_valid & st.ap_write;
  assign ap_take = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (st.ap_valid && !st.ap_write)
    begin
      case (st.ap_addr)
        OFS_CTRL:
        begin
          hrdata[CTRL_FULL_CLOSED] = st.full_closed;
          hrdata[CTRL_DIR_REV] = st.scale_direction_reverse;
        end
        OFS_STATUS: hrdata = {24'h0, st.status};
        OFS_MASK: hrdata = {24'h0, st.mask};
        OFS_CODE:
        begin
          hrdata[7:0] = st.code_main;
          hrdata[CODE_SUB_LSB +: 8] = st.code_sub;
          hrdata[CODE_VALID_BIT] = st.code_valid;
        end
        OFS_POS_LIM: hrdata = st.position_deviation_limit;
        OFS_SPD_LIM: hrdata = st.speed_deviation_limit;
        OFS_HYB_LIM: hrdata = st.hybrid_deviation_limit;
        OFS_OVS1: hrdata = st.overspeed_level;
        OFS_OVS2: hrdata = st.second_overspeed_level;
        OFS_RATIO_NUM: hrdata = {16'h0, st.scale_ratio_numerator};
        OFS_RATIO_DEN: hrdata = {16'h0, st.scale_ratio_denominator};
        OFS_DISC_TMO: hrdata = st.disc_timeout;
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  logic code_clear;
  logic [NFAULT-1:0] w1c;

  always_comb
  begin
    next_st = st;
    code_clear = 1'b0;
    w1c = '0;

    // Address phase capture
    next_st.ap_valid = ap_take;
    next_st.ap_write = hwrite;
    next_st.ap_addr = haddr[7:0];

    // Data phase writes
    if (wr_en)
    begin
      case (st.ap_addr)
        OFS_CTRL:
        begin
          next_st.full_closed = hwdata[CTRL_FULL_CLOSED];
          next_st.scale_direction_reverse = hwdata[CTRL_DIR_REV];
          code_clear = hwdata[CTRL_CODE_CLEAR];
        end
        OFS_STATUS: w1c = hwdata[NFAULT-1:0];
        OFS_MASK: next_st.mask = hwdata[NFAULT-1:0];
        OFS_POS_LIM: next_st.position_deviation_limit = hwdata;
        OFS_SPD_LIM: next_st.speed_deviation_limit = hwdata;
        OFS_HYB_LIM: next_st.hybrid_deviation_limit = hwdata;
        OFS_OVS1: next_st.overspeed_level = hwdata;
        OFS_OVS2: next_st.second_overspeed_level = hwdata;
        OFS_RATIO_NUM: next_st.scale_ratio_numerator = hwdata[15:0];
        OFS_RATIO_DEN: next_st.scale_ratio_denominator = hwdata[15:0];
        OFS_DISC_TMO: next_st.disc_timeout = hwdata;
        default: next_st.mask = st.mask;
      endcase
    end

    // Sticky status, a new detection wins over a write-one clear
    next_st.status = (st.status & ~w1c) | detect; // R12

    // Disconnection watchdog
    next_st.disc_cnt = next_disc_cnt;
    next_st.disc_flag = next_disc; // R1

    // Latched code of the first fault, lowest bit first on a tie
    if (code_clear)
    begin
      next_st.code_valid = 1'b0;
    end
    if (!st.code_valid || code_clear)
    begin
      for (int i = NFAULT - 1; i >= 0; i--)
      begin
        if (detect[i])
        begin
          next_st.code_valid = 1'b1; // R12
          next_st.code_main = FAULT_MAIN[i]; // R12
          next_st.code_sub = FAULT_SUB[i]; // R12
        end
      end
    end

    // Over-travel pin synchroniser
    next_st.ot_meta = overtravel_stop;
    next_st.ot_sync = st.ot_meta;
    next_st.cmd_eff = eff_cmd; // R7
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      st <= '0;
      st.mask <= RST_MASK;
      st.position_deviation_limit <= RST_POS_LIM;
      st.speed_deviation_limit <= RST_SPD_LIM;
      st.hybrid_deviation_limit <= RST_HYB_LIM;
      st.overspeed_level <= RST_OVS1;
      st.second_overspeed_level <= RST_OVS2;
      st.scale_ratio_numerator <= RST_RATIO;
      st.scale_ratio_denominator <= RST_RATIO;
      st.disc_timeout <= DISC_TIMEOUT_CYC;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign cmd_speed_eff = st.cmd_eff;
  assign fault_valid = st.code_valid;
  assign fault_main = st.code_main;
  assign fault_sub = st.code_sub;
  assign irq = |(st.status & st.mask);

endmodule

//--- sfm_checker.sv
// Port-level assertions for the servo fault monitor
`timescale 1ns/10ps
module sfm_checker
  import sfm_pkg::*;
#(
  parameter logic [31:0] DISC_TIMEOUT_CYC = 32'(DISC_TIME_CYC)
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Encoder and loop
  input wire logic enc_frame_stb,
  input wire logic enc_frame_err,
  input wire logic enc_data_bad,
  input wire logic signed [31:0] cmd_speed,
  input wire logic overtravel_stop,
  // Results
  input wire logic signed [31:0] cmd_speed_eff,
  input wire logic fault_valid,
  input wire logic [7:0] fault_main,
  input wire logic [7:0] fault_sub,
  input wire logic irq
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // Control write in its data phase
  logic wr_ctrl;
  logic clr;
  always_ff @(posedge clk_sys)
    wr_ctrl <= !srst && hsel && htrans[1] && hready && hwrite && haddr[7:0] == OFS_CTRL;
  assign clr = wr_ctrl && hwdata[CTRL_CODE_CLEAR];
  // ****************************************
  // Assertions
  // ****************************************
  sequence stop_held;
    overtravel_stop [*4];
  endsequence
  sequence run_held;
    !overtravel_stop [*4];
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or erred");
  chk_reset_quiet: assert property ($fell(srst) |-> !irq && !fault_valid)
    else $error("outputs active after reset");
  chk_stop_zero: assert property (stop_held |=> cmd_speed_eff == 32'sh0)
    else $error("command speed not forced to zero");
  chk_run_pass: assert property (run_held |=> cmd_speed_eff == $past(cmd_speed))
    else $error("command speed not passed on");
  chk_code_legal: assert property (fault_valid |-> {fault_main, fault_sub} inside
    {16'h1500, 16'h1501, 16'h1700, 16'h1800, 16'h1801, 16'h1900, 16'h1a00, 16'h1a01})
    else $error("unknown fault code");
  chk_code_keep: assert property (fault_valid && $past(fault_valid) && !$past(clr) |->
    $stable(fault_main) && $stable(fault_sub))
    else $error("latched code changed");
  chk_valid_hold: assert property (fault_valid && !clr |=> fault_valid)
    else $error("latched code lost");
  chk_data_code: assert property (!fault_valid && enc_frame_stb && !enc_frame_err && enc_data_bad |=>
    fault_valid && fault_main == 8'h17 && fault_sub == 8'h00)
    else $error("bad content frame not reported");
endmodule
bind sfm_top sfm_checker #(.DISC_TIMEOUT_CYC(DISC_TIMEOUT_CYC)) chk (.clk_sys, .srst, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hreadyout, .hresp, .enc_frame_stb, .enc_frame_err, .enc_data_bad, .cmd_speed,
  .overtravel_stop, .cmd_speed_eff, .fault_valid, .fault_main, .fault_sub, .irq);

//--- sfm_enc_model.sv
// Behavioural encoder frame source for the servo fault monitor bench
`timescale 1ns/10ps
module sfm_enc_model
#(
  parameter int PERIOD = 4
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Frame kind: 0 silent, 1 good, 2 transport error, 3 bad content
  input wire logic [1:0] mode,
  // Frame strobe and qualifiers
  output logic stb = 1'b0,
  output logic err = 1'b0,
  output logic bad = 1'b0
);
  int cnt = 0;
  // Qualifiers mean nothing between frames, so they keep toggling there
  always @(posedge clk_sys)
  begin
    cnt <= (srst || cnt == PERIOD - 1) ? 0 : cnt + 1;
    stb <= !srst && mode != 2'h0 && cnt == PERIOD - 1;
    err <= (cnt == PERIOD - 1) ? mode == 2'h2 : !err;
    bad <= (cnt == PERIOD - 1) ? mode == 2'h3 : !bad;
  end
endmodule

//--- tb_top.sv
// Self-checking testbench of the servo fault monitor
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("unexpected %0t %h %h", $time, a, b); end end
module tb_top;
  import sfm_pkg::*;
  int error_cnt = 0, checks = 0;
  logic clk_sys = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, overtravel_stop = 1'b0;
  logic [1:0] htrans = 2'h0, mode = 2'h1;
  logic [2:0] cfg = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic signed [31:0] position_deviation = 0, cmd_speed = 0, actual_speed = 0, motor_position = 0;
  logic signed [31:0] scale_position = 0, cmd_speed_eff;
  logic hready, hreadyout, hresp, enc_frame_stb, enc_frame_err, enc_data_bad, fault_valid, irq;
  logic [7:0] fault_main, fault_sub;
  assign hready = hreadyout;
  always #10 clk_sys = ~clk_sys;
  sfm_top #(.DISC_TIMEOUT_CYC(32'd20)) dut (.clk_sys, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .enc_frame_stb, .enc_frame_err, .enc_data_bad, .position_deviation,
    .cmd_speed, .actual_speed, .motor_position, .scale_position, .overtravel_stop, .cmd_speed_eff, .fault_valid,
    .fault_main, .fault_sub, .irq);
  sfm_enc_model #(.PERIOD(4)) enc (.clk_sys, .srst, .mode, .stb(enc_frame_stb), .err(enc_frame_err),
    .bad(enc_data_bad));
  // ****************************************
  // Bus and check helpers
  // ****************************************
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic code(input logic v, input logic [7:0] m, input logic [7:0] s);
    `CHK(fault_valid, v)
    if (v)
    begin
      `CHK(fault_main, m)
      `CHK(fault_sub, s)
    end
  endtask
  task automatic drv(input logic signed [31:0] p, c, a, m, s);
    position_deviation <= p;
    cmd_speed <= c;
    actual_speed <= a;
    motor_position <= m;
    scale_position <= s;
    @(posedge clk_sys);
  endtask
  task automatic clr();
    drv(0, 0, 0, 0, 0);
    bus(OFS_STATUS, 1'b1, 32'hff);
    bus(OFS_CTRL, 1'b1, {29'h0, cfg} | 32'h4);
    @(posedge clk_sys);
    code(1'b0, 8'h0, 8'h0);
  endtask
  task automatic lvl(input logic signed [31:0] p, c, a, m, s, input logic v, input logic [7:0] mm, ss);
    bus(OFS_CTRL, 1'b1, {29'h0, cfg});
    drv(p, c, a, m, s);
    repeat (2) @(posedge clk_sys);
    code(v, mm, ss);
    clr();
  endtask
  task automatic t_enc();
    bus(OFS_DISC_TMO, 1'b0, 32'h0);
    `CHK(rd, 32'd20)
    mode <= 2'h0;
    repeat (30) @(posedge clk_sys);
    code(1'b1, 8'h15, 8'h00);
    for (int i = 2; i < 4; i++)
    begin
      mode <= 2'h1;
      repeat (6) @(posedge clk_sys);
      clr();
      mode <= i[1:0];
      repeat (6) @(posedge clk_sys);
      code(1'b1, (i == 2) ? 8'h15 : 8'h17, (i == 2) ? 8'h01 : 8'h00);
    end
    mode <= 2'h1;
    repeat (6) @(posedge clk_sys);
    clr();
    $display("encoder test done");
  endtask
  task automatic t_lvl();
    lvl(32'h4e20, 0, 0, 0, 0, 1'b0, 8'h0, 8'h0);
    lvl(32'h4e21, 0, 0, 0, 0, 1'b1, 8'h18, 8'h00);
    lvl(0, 32'h7fff, 0, 0, 0, 1'b0, 8'h0, 8'h0);
    bus(OFS_SPD_LIM, 1'b1, 32'h100);
    lvl(0, 32'h101, 0, 0, 0, 1'b1, 8'h18, 8'h01);
    bus(OFS_SPD_LIM, 1'b1, 32'h0);
    lvl(0, 0, 32'h1771, 0, 0, 1'b1, 8'h1a, 8'h00);
    bus(OFS_OVS1, 1'b1, 32'hffff);
    lvl(0, 0, 32'h1b59, 0, 0, 1'b1, 8'h1a, 8'h01);
    lvl(0, 0, 0, 0, 32'h4e21, 1'b0, 8'h0, 8'h0);
    cfg = 3'h1;
    lvl(0, 0, 0, 0, 32'h4e21, 1'b1, 8'h19, 8'h00);
    bus(OFS_RATIO_NUM, 1'b1, 32'h2);
    lvl(0, 0, 0, 32'h9c42, 32'h4e21, 1'b0, 8'h0, 8'h0);
    cfg = 3'h3;
    lvl(0, 0, 0, 32'h9c42, -32'sh4e21, 1'b0, 8'h0, 8'h0);
    lvl(0, 0, 0, 32'h9c42, 32'h4e21, 1'b1, 8'h19, 8'h00);
    bus(OFS_RATIO_DEN, 1'b1, 32'h2);
    lvl(0, 0, 0, 32'h4e20, 0, 1'b0, 8'h0, 8'h0);
    lvl(0, 0, 0, 32'h4e21, 0, 1'b1, 8'h19, 8'h00);
    $display("threshold test done");
  endtask
  task automatic t_ovt();
    bus(OFS_SPD_LIM, 1'b1, 32'h100);
    drv(0, 32'h200, 32'h200, 0, 0);
    repeat (4) @(posedge clk_sys);
    code(1'b0, 8'h0, 8'h0);
    `CHK(cmd_speed_eff, 32'sh200)
    overtravel_stop <= 1'b1;
    repeat (6) @(posedge clk_sys);
    code(1'b1, 8'h18, 8'h01);
    `CHK(cmd_speed_eff, 32'sh0)
    overtravel_stop <= 1'b0;
    bus(OFS_SPD_LIM, 1'b1, 32'h0);
    clr();
    $display("overtravel test done");
  endtask
  task automatic t_irq();
    bus(8'h40, 1'b1, 32'hffffffff);
    bus(8'h40, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    bus(OFS_MASK, 1'b1, 32'h0);
    drv(0, 0, 32'h1b59, 0, 0);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    bus(OFS_STATUS, 1'b0, 32'h0);
    `CHK(rd[7:0], 8'h80)
    bus(OFS_MASK, 1'b1, 32'h80);
    drv(0, 0, 0, 0, 0);
    `CHK(irq, 1'b1)
    bus(OFS_STATUS, 1'b1, 32'h80);
    @(posedge clk_sys);
    `CHK(irq, 1'b0)
    code(1'b1, 8'h1a, 8'h01);
    clr();
    $display("interrupt test done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_enc();
    t_lvl();
    t_ovt();
    t_irq();
    results();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    results();
  end
endmodule
